/* design/ucr_pkg.sv */
package ucr_pkg;
  // Register map
  localparam logic [7:0] REG_PCE = 8'h00;
  localparam logic [7:0] REG_SPS = 8'h04;
  localparam logic [7:0] REG_BIT = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  // Clock supply gate
  localparam int PCE_UNIT_BIT = 2;
  localparam logic [7:0] PCE_RESET = 8'h04;
  localparam logic [7:0] PCE_MASK = 8'hbd;
  // Prescaler select
  localparam logic [15:0] SPS_RESET = 16'h0000;
  localparam int CODE_W = 4;
  localparam int PRE_W = 15;
  // Line timing
  localparam int CLK_HZ = 125_000_000;
  localparam int LINE_BPS = 9600;
  localparam logic [15:0] BIT_DIV_DEF = 16'((CLK_HZ + LINE_BPS / 2) / LINE_BPS);
  localparam int BIT_SEL_BIT = 16;
  localparam logic [3:0] RX_STOP_IDX = 4'ha;
  localparam logic [3:0] TX_FRAME_BITS = 4'hb;
  // Ring
  localparam int RING_DEPTH = 16;
  localparam int RING_AW = 4;
  localparam logic [RING_AW:0] RING_FULL = 5'h10;
  localparam logic [2:0] REPLY_LEN = 3'h4;
  // Characters
  localparam logic [7:0] CH_T_UP = 8'h54;
  localparam logic [7:0] CH_T_LO = 8'h74;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  // Reply codes held in the ring
  typedef enum logic [2:0] {
    CODE_OK = 3'h0,
    CODE_OK_LO = 3'h1,
    CODE_UC = 3'h2,
    CODE_PE = 3'h3,
    CODE_FE = 3'h4,
    CODE_OE = 3'h5
  } ucr_code_t;
  // Responder states, Gray along start, wait, send
  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_WAIT = 2'b01,
    ST_SEND = 2'b11
  } ucr_state_t;
endpackage : ucr_pkg

/* design/ucr_top.sv */
// Summary of operation
// - After reset both channels run, responder waits, receive and error events enabled.
// - An error entry fetched from the ring sends its matching error reply.
// - Error replies are four characters, three kinds at most.
// - First byte loaded directly, later bytes only on transmit-end events.
// - Reply ends after four characters; reception keeps working meanwhile.
// - Ring stores data replies or error entries only when space remains.
// - Each store reports full as 1 when dropped, 0 when stored.
// - Reads return the oldest entry first whenever one is held.
// - Each read reports empty as 1 when nothing read, 0 when valid.
// - Receive-complete queues the matching reply if space, else drops it.
// - Reception error clears any pending receive-complete request.
// - Reception error queues its status if space, else drops it.
// - Transmit-end decrements remaining count, sends next byte while nonzero.
// - Count reaching zero disables transmit-end events and finishes the reply.
// - Unit clock enable bit starts or stops the serial unit clock.
// - Each operation clock is the system clock over two to the code.
// - T gives OK CR LF, t gives ok CR LF, others UC CR LF.
// - Parity, framing, overrun errors give PE, FE, OE then CR LF.
// - Line uses 8 data bits, LSB first, even parity, 9600 bps.
`timescale 1ns/1ps
`default_nettype none
module ucr_top #(
  parameter logic [15:0] BIT_DIV = ucr_pkg::BIT_DIV_DEF
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic serial_rx_line,
  output logic [31:0] reg_rdata,
  output logic serial_tx_line
);

  function automatic logic [7:0] reply_char(input logic [2:0] code, input logic [1:0] idx);
    logic [7:0] c;
    c = ucr_pkg::CH_LF;
    unique case (idx)
      2'h0: begin
        unique case (code)
          ucr_pkg::CODE_OK: c = "O";
          ucr_pkg::CODE_OK_LO: c = "o";
          ucr_pkg::CODE_PE: c = "P";
          ucr_pkg::CODE_FE: c = "F";
          ucr_pkg::CODE_OE: c = "O";
          default: c = "U";
        endcase
      end
      2'h1: begin
        unique case (code)
          ucr_pkg::CODE_OK: c = "K";
          ucr_pkg::CODE_OK_LO: c = "k";
          ucr_pkg::CODE_UC: c = "C";
          default: c = "E";
        endcase
      end
      2'h2: c = ucr_pkg::CH_CR;
      2'h3: c = ucr_pkg::CH_LF;
    endcase
    return c;
  endfunction : reply_char

  logic [7:0] pce_q;
  logic [15:0] sps_q, div_q, rx_ph_q, tx_ph_q;
  logic [ucr_pkg::PRE_W-1:0] pre_cnt_q;
  logic [1:0] op_tick;
  logic [2:0] rx_sync_q, rx_code_q, err_code_q, rem_q, cur_code_q;
  logic [3:0] rx_idx_q, tx_bits_q;
  logic [8:0] rx_sh_q;
  logic [9:0] tx_sh_q;
  logic clk_sel_q, rx_s_q, rx_busy_q, tx_done_en_q, tx_end_q, tx_q, put_full_q, get_empty_q;
  logic rx_done_pend_q, rx_err_pend_q, rx_done_en_q, rx_err_en_q;
  logic [7:0] ring_mem [ucr_pkg::RING_DEPTH];
  logic [ucr_pkg::RING_AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [ucr_pkg::RING_AW:0] cnt_q;
  ucr_pkg::ucr_state_t state_q;

  wire unit_run = pce_q[ucr_pkg::PCE_UNIT_BIT];

  // Register decode
  wire wr_pce = reg_wr && (reg_addr == ucr_pkg::REG_PCE);
  wire wr_sps = reg_wr && (reg_addr == ucr_pkg::REG_SPS);
  wire wr_bit = reg_wr && (reg_addr == ucr_pkg::REG_BIT);
  wire [31:0] stat_word = {10'h000, get_empty_q, put_full_q, rx_err_pend_q, rx_done_pend_q,
                           state_q, 1'b0, tx_done_en_q, rx_err_en_q, rx_done_en_q, 1'b0,
                           rem_q, 3'h0, cnt_q};
  wire [31:0] rd_mux =
    (reg_addr == ucr_pkg::REG_PCE) ? {24'h000000, pce_q} :
    (reg_addr == ucr_pkg::REG_SPS) ? {16'h0000, sps_q} :
    (reg_addr == ucr_pkg::REG_BIT) ? {15'h0000, clk_sel_q, div_q} :
    (reg_addr == ucr_pkg::REG_STAT) ? stat_word : 32'h00000000;

  // Software registers; unmapped writes are ignored
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pce_q <= ucr_pkg::PCE_RESET;
      sps_q <= ucr_pkg::SPS_RESET;
      div_q <= BIT_DIV;
      clk_sel_q <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else begin
      if (wr_pce) pce_q <= reg_wdata[7:0] & ucr_pkg::PCE_MASK;
      if (wr_sps) sps_q <= {8'h00, reg_wdata[7:0]};
      if (wr_bit) begin
        div_q <= reg_wdata[15:0];
        clk_sel_q <= reg_wdata[ucr_pkg::BIT_SEL_BIT];
      end
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  // Free prescaler counter, frozen while the unit clock is off
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) pre_cnt_q <= '0;
    else if (unit_run) pre_cnt_q <= pre_cnt_q + 1'b1;
  end

  // one enable pulse per 2^code cycles, code zero every cycle
  for (genvar g = 0; g < 2; g++) begin : g_opclk
    wire [ucr_pkg::CODE_W-1:0] code = sps_q[g*ucr_pkg::CODE_W +: ucr_pkg::CODE_W];
    wire [ucr_pkg::PRE_W-1:0] mask = ucr_pkg::PRE_W'((16'h0001 << code) - 16'h0001);
    assign op_tick[g] = unit_run && ((pre_cnt_q & mask) == '0);
  end
  wire tick = op_tick[clk_sel_q];

  // Three-stage pin sync; level moves only when stages two and three agree
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_sync_q <= 3'h7;
      rx_s_q <= 1'b1;
    end else begin
      rx_sync_q <= {rx_sync_q[1:0], serial_rx_line};
      if (rx_sync_q[1] == rx_sync_q[2]) rx_s_q <= rx_sync_q[2];
    end
  end

  // Receiver sampling at mid-bit
  wire rx_start = unit_run && !rx_busy_q && !rx_s_q;
  wire rx_samp = rx_busy_q && tick && (rx_ph_q == 16'h0000);
  wire rx_end = rx_samp && (rx_idx_q == ucr_pkg::RX_STOP_IDX);
  // even parity over data and parity bit
  wire par_err = ^rx_sh_q;
  wire fr_err = !rx_s_q;
  wire ovr_err = rx_done_pend_q;
  wire rx_bad = par_err || fr_err || ovr_err;
  wire [2:0] err_code = par_err ? ucr_pkg::CODE_PE :
                        fr_err ? ucr_pkg::CODE_FE : ucr_pkg::CODE_OE;
  wire [2:0] data_code = (rx_sh_q[7:0] == ucr_pkg::CH_T_UP) ? ucr_pkg::CODE_OK :
                         (rx_sh_q[7:0] == ucr_pkg::CH_T_LO) ? ucr_pkg::CODE_OK_LO :
                         ucr_pkg::CODE_UC;
  wire ev_done = rx_end && !rx_bad && rx_done_en_q;
  wire ev_err = rx_end && rx_bad && rx_err_en_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_busy_q <= 1'b0;
      rx_idx_q <= 4'h0;
      rx_ph_q <= 16'h0000;
      rx_sh_q <= 9'h000;
    end else if (rx_start) begin
      rx_busy_q <= 1'b1;
      rx_idx_q <= 4'h0;
      rx_ph_q <= div_q >> 1;
    end else if (rx_busy_q && tick) begin
      if (rx_ph_q != 16'h0000) begin
        rx_ph_q <= rx_ph_q - 16'h0001;
      end else begin
        rx_ph_q <= div_q - 16'h0001;
        rx_idx_q <= rx_idx_q + 4'h1;
        // False start or stop bit ends the frame
        if ((rx_idx_q == 4'h0 && rx_s_q) || rx_end) rx_busy_q <= 1'b0;
        else if (rx_idx_q != 4'h0) rx_sh_q <= {rx_s_q, rx_sh_q[8:1]};
      end
    end
  end

  // Ring write service, error entry first
  wire put_req = unit_run && (rx_err_pend_q || rx_done_pend_q);
  wire svc_err = put_req && rx_err_pend_q;
  wire svc_done = put_req && !rx_err_pend_q;
  wire [2:0] put_code = rx_err_pend_q ? err_code_q : rx_code_q;
  wire ring_full = (cnt_q == ucr_pkg::RING_FULL);
  wire ring_empty = (cnt_q == '0);
  wire do_put = put_req && !ring_full;
  // fetch when idle and not empty
  wire get_try = unit_run && (state_q == ucr_pkg::ST_WAIT);
  wire do_get = get_try && !ring_empty;
  wire [2:0] get_code = ring_mem[rd_ptr_q][2:0];

  // Pending events; a new event wins over its own service
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rx_done_pend_q <= 1'b0;
      rx_err_pend_q <= 1'b0;
      rx_code_q <= ucr_pkg::CODE_UC;
      err_code_q <= ucr_pkg::CODE_PE;
    end else begin
      if (ev_err) rx_done_pend_q <= 1'b0;
      else if (ev_done) rx_done_pend_q <= 1'b1;
      // serviced even when full, then dropped
      else if (svc_done) rx_done_pend_q <= 1'b0;
      if (ev_done) rx_code_q <= data_code;
      if (ev_err) rx_err_pend_q <= 1'b1;
      else if (svc_err) rx_err_pend_q <= 1'b0;
      if (ev_err) err_code_q <= err_code;
    end
  end

  // ring storage, no reset needed on data
  always_ff @(posedge mclk) begin
    if (do_put) ring_mem[wr_ptr_q] <= {5'h00, put_code};
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
      put_full_q <= 1'b0;
      get_empty_q <= 1'b1;
    end else begin
      if (do_put) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (do_get) rd_ptr_q <= rd_ptr_q + 1'b1;
      if (do_put && !do_get) cnt_q <= cnt_q + 1'b1;
      else if (do_get && !do_put) cnt_q <= cnt_q - 1'b1;
      if (put_req) put_full_q <= ring_full;
      if (get_try) get_empty_q <= ring_empty;
    end
  end

  // Transmit sequencing
  wire [2:0] rem_dec = rem_q - 3'h1;
  wire tx_ev = tx_end_q && tx_done_en_q;
  wire tx_next = tx_ev && (rem_dec != 3'h0);
  wire tx_load = do_get || tx_next;
  // byte of the fetched or current reply
  wire [7:0] tx_byte = do_get ? reply_char(get_code, 2'h0) :
                       reply_char(cur_code_q, 2'(ucr_pkg::REPLY_LEN - rem_dec));

  // Responder state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ucr_pkg::ST_START;
      rx_done_en_q <= 1'b0;
      rx_err_en_q <= 1'b0;
      tx_done_en_q <= 1'b0;
      rem_q <= 3'h0;
      cur_code_q <= ucr_pkg::CODE_UC;
    end else begin
      unique case (state_q)
        ucr_pkg::ST_START: begin
          rx_done_en_q <= 1'b1;
          rx_err_en_q <= 1'b1;
          state_q <= ucr_pkg::ST_WAIT;
        end
        // load count to four on fetch
        ucr_pkg::ST_WAIT: begin
          if (do_get) begin
            cur_code_q <= get_code;
            rem_q <= ucr_pkg::REPLY_LEN;
            tx_done_en_q <= 1'b1;
            state_q <= ucr_pkg::ST_SEND;
          end
        end
        ucr_pkg::ST_SEND: begin
          if (tx_ev) begin
            rem_q <= rem_dec;
            // zero ends reply and masks events
            if (rem_dec == 3'h0) begin
              tx_done_en_q <= 1'b0;
              state_q <= ucr_pkg::ST_WAIT;
            end
          end
        end
      endcase
    end
  end

  // start, data LSB first, even parity, stop
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_sh_q <= 10'h3ff;
      tx_bits_q <= 4'h0;
      tx_ph_q <= 16'h0000;
      tx_end_q <= 1'b0;
      tx_q <= 1'b1;
    end else begin
      tx_end_q <= 1'b0;
      if (tx_load) begin
        tx_q <= 1'b0;
        tx_sh_q <= {1'b1, ^tx_byte, tx_byte};
        tx_bits_q <= ucr_pkg::TX_FRAME_BITS;
        tx_ph_q <= div_q - 16'h0001;
      end else if (tick && tx_bits_q != 4'h0) begin
        if (tx_ph_q != 16'h0000) begin
          tx_ph_q <= tx_ph_q - 16'h0001;
        end else begin
          tx_ph_q <= div_q - 16'h0001;
          tx_bits_q <= tx_bits_q - 4'h1;
          // Stop bit has had its full time when the count empties
          if (tx_bits_q == 4'h1) begin
            tx_end_q <= 1'b1;
          end else begin
            tx_q <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
          end
        end
      end
    end
  end

  assign serial_tx_line = tx_q;
endmodule : ucr_top
`default_nettype wire

/* verification/ucr_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// Remote terminal: sends characters, collects reply bytes
module ucr_partner #(
  parameter int BIT_CYC = 8
) (
  input wire logic mclk,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] got_q[$];
  logic [9:0] sh;
  int bad_frames = 0;
  initial line_out = 1'b1;
  // even parity, LSB first; kind 1 spoils parity, kind 2 the stop bit
  task automatic send_char(input logic [7:0] c, input int kind);
    logic [10:0] fr;
    fr = {kind != 2, ^c ^ (kind == 1), c, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_out <= fr[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
    // Low stop bit must be followed by a real idle bit
    if (kind == 2) begin
      line_out <= 1'b1;
      repeat (BIT_CYC) @(posedge mclk);
    end
  endtask : send_char
  // reply bytes sampled mid-bit, LSB first; parity and stop judged too
  always begin
    @(negedge line_in);
    repeat (BIT_CYC / 2) @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYC) @(posedge mclk);
      sh[i] = line_in;
    end
    if (^sh[8:0] || !sh[9]) bad_frames++;
    got_q.push_back(sh[7:0]);
  end
endmodule : ucr_partner
`default_nettype wire

/* verification/ucr_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ucr_top_asserts (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic serial_rx_line,
  input wire logic [31:0] reg_rdata,
  input wire logic serial_tx_line
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Status read decode
  logic stat_rd;
  assign stat_rd = reg_rd && reg_addr == ucr_pkg::REG_STAT;
  AST_SPS_HIGH: assert property (
    reg_rd && reg_addr == ucr_pkg::REG_SPS |=> reg_rdata[31:8] == 24'h0)
    else $error("prescaler select high bits not zero");
  AST_PCE_FIXED: assert property (
    reg_rd && reg_addr == ucr_pkg::REG_PCE |=> (reg_rdata & ~32'h000000bd) == 32'h0)
    else $error("clock enable fixed bits set");
  AST_RING_COUNT: assert property (stat_rd |=> reg_rdata[4:0] <= 5'h10)
    else $error("ring count above depth");
  AST_TX_COUNT: assert property (stat_rd |=> reg_rdata[10:8] <= 3'h4)
    else $error("remaining count above four");
  AST_WAIT_IDLE: assert property (
    stat_rd ##1 reg_rdata[17:16] == 2'b01 |-> reg_rdata[10:8] == 3'h0 && !reg_rdata[14])
    else $error("waiting with count or tx event enabled");
  AST_RX_ENABLED: assert property (stat_rd |=> reg_rdata[13:12] == 2'b11)
    else $error("receive events not enabled");
  // Shortest bit at the test rates is seven cycles, a start bit at code one; one kept as margin
  AST_LOW_BIT: assert property ($fell(serial_tx_line) |-> !serial_tx_line [*6])
    else $error("low bit too short");
  AST_HIGH_BIT: assert property ($rose(serial_tx_line) |-> serial_tx_line [*6])
    else $error("high bit too short");
  AST_RESET_IDLE: assert property ($rose(resetn) |-> serial_tx_line && reg_rdata == 32'h0)
    else $error("outputs not idle after reset");
  cover property (stat_rd);
  cover property ($fell(serial_tx_line));
  cover property (reg_wr && reg_addr == ucr_pkg::REG_SPS);
endmodule : ucr_top_asserts
bind ucr_top ucr_top_asserts u_chk (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .serial_rx_line(serial_rx_line),
  .reg_rdata(reg_rdata), .serial_tx_line(serial_tx_line));
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int BC = 8;
  logic mclk;
  logic resetn;
  logic reg_wr;
  logic reg_rd;
  logic rx_line;
  logic tx_line;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] rd_q;
  logic [7:0] sent_q[$];
  // Prescaler and divisor pairs that all give eight cycles per bit
  // Codes above one let the tick phase eat the start bit and miss mid-bit
  logic [31:0] sps_t[5] = '{32'h0, 32'h1, 32'h10, 32'h10, 32'h1};
  logic [31:0] bit_t[5] = '{32'h8, 32'h4, 32'h10004, 32'h8, 32'h10008};
  int mismatches;
  int checked;
  ucr_top dut (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .serial_rx_line(rx_line), .reg_rdata(reg_rdata),
    .serial_tx_line(tx_line));
  ucr_partner #(.BIT_CYC(BC)) peer (.mclk(mclk), .line_in(tx_line), .line_out(rx_line));
  always #4 mclk = ~mclk;
  // Four reply characters for a received char or an error kind
  function automatic logic [31:0] reply(input logic [7:0] c, input int kind);
    logic [15:0] w;
    w = (kind == 1) ? 16'h5045 : (kind == 2) ? 16'h4645 : (c == 8'h54) ? 16'h4f4b :
      (c == 8'h74) ? 16'h6f6b : 16'h5543;
    return {w, 8'h0d, 8'h0a};
  endfunction : reply
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  // Data is taken at the edge closing the answer cycle
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    rd_q = reg_rdata;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_q, e);
  endtask : rchk
  // Bounded wait for four bytes; a short reply keeps unknowns and fails
  task automatic expect_reply(input logic [31:0] exp);
    logic [31:0] got;
    int n;
    got = 'x;
    n = 0;
    while (peer.got_q.size() < 4 && n < 200 * BC) begin
      @(posedge mclk);
      n++;
    end
    for (int i = 0; i < 4 && peer.got_q.size() > 0; i++) got = {got[23:0], peer.got_q.pop_front()};
    chk(got, exp);
  endtask : expect_reply
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [7:0] c;
    int n;
    logic full_seen;
    logic depth_seen;
    mclk = 1'b0;
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    n = $urandom(6338);
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rchk(ucr_pkg::REG_PCE, 32'h00000004);
    rchk(ucr_pkg::REG_STAT, 32'h00213000);
    rchk(ucr_pkg::REG_SPS, 32'h0);
    rchk(8'h10, 32'h0);
    wr(ucr_pkg::REG_SPS, 32'hffffffff);
    rchk(ucr_pkg::REG_SPS, 32'h000000ff);
    wr(ucr_pkg::REG_PCE, 32'hffffffff);
    rchk(ucr_pkg::REG_PCE, 32'h000000bd);
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      wr(ucr_pkg::REG_SPS, sps_t[i]);
      wr(ucr_pkg::REG_BIT, bit_t[i]);
      c = (i == 0) ? 8'h54 : (i == 1) ? 8'h74 : 8'($urandom);
      peer.send_char(c, 0);
      expect_reply(reply(c, 0));
    end
    $display("test prescaler done");
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      peer.send_char(c, 0);
      expect_reply(reply(c, 0));
    end
    $display("test characters done");
    // Parity error first: nothing may follow its reply
    for (int k = 1; k < 3; k++) begin
      peer.send_char(8'($urandom), k);
      expect_reply(reply(8'h00, k));
      repeat (150 * BC) @(posedge mclk);
      if (k == 1) chk(32'(peer.got_q.size()), 32'h0);
      peer.got_q.delete();
    end
    $display("test errors done");
    // Flood so the ring overflows; late chars all give UC, whichever are dropped
    full_seen = 1'b0;
    depth_seen = 1'b0;
    for (int i = 0; i < 30; i++) begin
      c = (i == 0) ? 8'h54 : (i == 5) ? 8'h74 : 8'($urandom);
      if (i >= 16 && (c == 8'h54 || c == 8'h74)) c[0] = 1'b1;
      sent_q.push_back(c);
      peer.send_char(c, 0);
      rd(ucr_pkg::REG_STAT);
      if (rd_q[20]) full_seen = 1'b1;
      if (rd_q[4:0] == 5'h10) depth_seen = 1'b1;
    end
    chk(32'(full_seen), 32'h1);
    chk(32'(depth_seen), 32'h1);
    repeat (1000 * BC) @(posedge mclk);
    n = peer.got_q.size() / 4;
    chk(32'(n >= 17 && n < 30 && peer.got_q.size() % 4 == 0), 32'h1);
    for (int i = 0; i < n; i++) expect_reply(reply(sent_q[i], 0));
    rd(ucr_pkg::REG_STAT);
    chk(rd_q & 32'h0003771f, 32'h00013000);
    $display("test ring done");
    wr(ucr_pkg::REG_PCE, 32'h0);
    peer.send_char(8'h54, 0);
    repeat (100 * BC) @(posedge mclk);
    chk(32'(peer.got_q.size()), 32'h0);
    wr(ucr_pkg::REG_PCE, 32'h4);
    repeat (20 * BC) @(posedge mclk);
    peer.send_char(8'h74, 0);
    expect_reply(reply(8'h74, 0));
    chk(32'(peer.bad_frames), 32'h0);
    $display("test clock gate done");
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
